// ### src/bfp_cfg.svh
// constants of the burst flash pin interface: widths, depths, protection map
// assumes inclusion by bare name from the package and the design file
`ifndef BFP_CFG_SVH
`define BFP_CFG_SVH

`define BFP_DW       16        // multiplexed address/data width
`define BFP_HW       7         // address-only upper bits
`define BFP_AW       23        // full word address width
`define BFP_ARR_AW   8         // implemented array index width
`define BFP_FIFO_D   16        // burst prefetch depth in words
`define BFP_FIFO_PW  4         // pointer width for that depth
`define BFP_SEC_MSB  22        // sector number, top address bit
`define BFP_SEC_LSB  12        // sector number, bottom address bit
`define BFP_SEC_W    11        // sector number width
`define BFP_WP_SEC0  11'h021   // first write-protected sector
`define BFP_WP_SEC1  11'h022   // second write-protected sector

`endif

// ### src/bfp_flash_if.sv
// prefetch fifo and device-side pin logic of the burst flash interface
// assumes one clk; host pins are synchronous to it; bus is split in/out/oe
`timescale 1ns/1ps
`default_nettype none
`include "bfp_cfg.svh"

// prefetch fifo with valid/ready on both sides and a flush
module bfp_fifo #(
  parameter int W = `BFP_DW,
  parameter int D = `BFP_FIFO_D
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(D);

  logic [W-1:0]       mem [D];       // word storage
  bfp_pkg::bfp_fifo_s r_reg;         // pointers and count
  bfp_pkg::bfp_fifo_s r_next;
  logic               push;          // accepted write
  logic               pop;           // accepted read

  // honest flags from the count
  assign in_ready  = (r_reg.cnt != (PW+1)'(D));
  assign out_valid = (r_reg.cnt != '0);
  assign out_data  = mem[r_reg.rp];
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;

  // pointer and count update, flush wins
  always_comb begin
    r_next = r_reg;
    if (flush) begin
      r_next = '0;
    end else begin
      if (push) begin
        r_next.wp = r_reg.wp + 1'b1;
      end
      if (pop) begin
        r_next.rp = r_reg.rp + 1'b1;
      end
      r_next.cnt = r_reg.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // storage write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[r_reg.wp] <= in_data;
    end
  end
endmodule // bfp_fifo

// Function
// RULE1 - first clocked strobe edge latches address, starts burst
// RULE2 - after first word, each edge advances counter
// RULE3 - host keeps flash clock low in asynchronous access
// RULE4 - ready high when bus word valid
// RULE5 - asynchronous mode: strobe low means address valid
// RULE6 - burst start address latched only with strobe low
// RULE7 - strobe high: address inputs ignored
// RULE8 - low address shares data lines, upper separate
// RULE9 - hardware reset returns device to array read
// RULE10 - write protect low blocks boot sector pair
// RULE11 - host keeps write protect high normally
// RULE12 - 12 V accelerates and bypasses; low disables programming
// RULE13 - chip and output enable act without clock
// RULE14 - host samples burst data only when ready
module bfp_flash_if (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire bfp_pkg::bfp_ctl_s    ctl,
  input  wire logic [`BFP_HW-1:0]   addr_hi,
  input  wire logic [`BFP_DW-1:0]   addr_data_bus_in,
  output logic [`BFP_DW-1:0]        addr_data_bus_out,
  output logic                      addr_data_bus_oe,
  output logic                      rdy,
  output logic                      accel_on,
  output logic                      bypass_on,
  output logic                      prog_refused
);
  logic [`BFP_DW-1:0]    arr [2**`BFP_ARR_AW];  // implemented array
  bfp_pkg::bfp_top_s     r_reg;                 // all block state
  bfp_pkg::bfp_top_s     r_next;
  logic                  rise;                  // flash_clk rising edge
  logic                  sel;                   // chip selected
  logic                  strobe;                // address valid
  logic [`BFP_AW-1:0]    pin_addr;              // address on the pins
  logic [`BFP_SEC_W-1:0] sector;                // sector of latched addr
  logic                  wp_hit;                // protected sector hit
  logic                  wr_en;                 // array write strobe
  logic                  f_push;                // prefetch push request
  logic                  f_pop;                 // burst word taken
  logic                  f_flush;               // drop prefetched words
  logic                  f_in_ready;
  logic                  f_out_valid;
  logic [`BFP_DW-1:0]    f_out_data;

  // pin decode; upper bits separate, lower bits off the shared bus
  assign pin_addr = {addr_hi, addr_data_bus_in};  // RULE8
  assign rise     = ctl.flash_clk & ~r_reg.clk_q;
  assign sel      = ~ctl.ce_n;
  assign strobe   = ~ctl.addr_valid_n;
  assign sector   = r_reg.addr[`BFP_SEC_MSB:`BFP_SEC_LSB];
  assign wp_hit   = ~ctl.wp_n & ((sector == `BFP_WP_SEC0) |
                                 (sector == `BFP_WP_SEC1));  // RULE10

  // burst prefetch buffer, drained one word per clock edge
  bfp_fifo #(
    .W (`BFP_DW),
    .D (`BFP_FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (f_flush),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .in_data   (arr[r_reg.fetch[`BFP_ARR_AW-1:0]]),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out_data)
  );

  // next-state logic of the whole interface
  always_comb begin
    r_next         = r_reg;
    f_push         = 1'b0;
    f_pop          = 1'b0;
    f_flush        = 1'b0;
    wr_en          = 1'b0;
    r_next.clk_q   = ctl.flash_clk;
    r_next.we_q    = ctl.we_n;
    r_next.refused = 1'b0;
    r_next.accel   = ctl.vpp_accel;  // RULE12
    if (ctl.vpp_accel) begin
      r_next.bypass = 1'b1;  // RULE12
    end
    if (!ctl.reset_hw_n) begin
      // hardware reset: back to array read, burst dropped
      r_next.st      = bfp_pkg::BFP_IDLE;  // RULE9
      r_next.started = 1'b0;
      r_next.dq_oe   = 1'b0;
      r_next.rdy     = 1'b1;
      r_next.bypass  = 1'b0;
      f_flush        = 1'b1;
    end else begin
      unique case (r_reg.st)
        bfp_pkg::BFP_IDLE: begin
          // asynchronous access: address followed while strobe low
          if (sel & strobe & ~ctl.flash_clk) begin
            r_next.addr = pin_addr;  // RULE5 RULE7
          end
          // clocked strobe opens a burst
          if (sel & strobe & rise) begin
            r_next.addr    = pin_addr;  // RULE1 RULE6
            r_next.fetch   = pin_addr;
            r_next.started = 1'b0;
            r_next.rdy     = 1'b0;
            r_next.st      = bfp_pkg::BFP_BURST;
            f_flush        = 1'b1;
          end else begin
            // array read, enables acted on every cycle
            r_next.dout  = arr[r_reg.addr[`BFP_ARR_AW-1:0]];
            r_next.dq_oe = sel & ~ctl.oe_n & ctl.we_n & ~strobe;  // RULE13
            r_next.rdy   = 1'b1;  // RULE4
          end
          // program on the rising we_n edge
          if (sel & ctl.we_n & ~r_reg.we_q) begin
            if (ctl.vpp_off | wp_hit) begin
              r_next.refused = 1'b1;  // RULE10 RULE12
            end else begin
              wr_en = 1'b1;
            end
          end
        end
        bfp_pkg::BFP_BURST: begin
          r_next.dq_oe = sel & ~ctl.oe_n;  // RULE13
          if (!sel) begin
            // deselect ends the burst at once
            r_next.st    = bfp_pkg::BFP_IDLE;  // RULE13
            r_next.dq_oe = 1'b0;
            r_next.rdy   = 1'b1;
            f_flush      = 1'b1;
          end else if (strobe & rise) begin
            // new start address restarts the burst
            r_next.addr    = pin_addr;  // RULE1 RULE6
            r_next.fetch   = pin_addr;
            r_next.started = 1'b0;
            r_next.rdy     = 1'b0;
            f_flush        = 1'b1;
          end else begin
            // keep the buffer filled ahead of the host
            if (f_in_ready) begin
              f_push       = 1'b1;
              r_next.fetch = r_reg.fetch + 1'b1;
            end
            if (rise) begin
              if (f_out_valid) begin
                f_pop          = 1'b1;
                r_next.dout    = f_out_data;
                r_next.rdy     = 1'b1;  // RULE4
                r_next.started = 1'b1;
                if (r_reg.started) begin
                  r_next.addr = r_reg.addr + 1'b1;  // RULE2
                end
              end else begin
                r_next.rdy = 1'b0;  // RULE4
              end
            end
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg       <= '0;
      r_reg.st    <= bfp_pkg::BFP_IDLE;
      r_reg.we_q  <= 1'b1;
      r_reg.rdy   <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // array write, no reset needed
  always_ff @(posedge clk) begin
    if (wr_en) begin
      arr[r_reg.addr[`BFP_ARR_AW-1:0]] <= addr_data_bus_in;
    end
  end

  // outputs straight from the state register
  assign addr_data_bus_out = r_reg.dout;
  assign addr_data_bus_oe  = r_reg.dq_oe;
  assign rdy               = r_reg.rdy;
  assign accel_on          = r_reg.accel;
  assign bypass_on         = r_reg.bypass;
  assign prog_refused      = r_reg.refused;
endmodule // bfp_flash_if

`default_nettype wire

// ### src/bfp_pkg.sv
// types of the burst flash pin interface
// assumes bfp_cfg.svh is on the include path
`include "bfp_cfg.svh"

package bfp_pkg;

  // control pins from the host, all sampled on clk
  typedef struct packed {
    logic ce_n;          // chip enable
    logic oe_n;          // output enable
    logic we_n;          // write enable
    logic addr_valid_n;  // address valid strobe
    logic flash_clk;     // interface clock, sampled level
    logic reset_hw_n;    // hardware reset pin
    logic wp_n;          // write protect pin
    logic vpp_accel;     // program-voltage pin at 12 V
    logic vpp_off;       // program-voltage pin at logic low
  } bfp_ctl_s;

  // access state
  typedef enum logic [1:0] {
    BFP_IDLE  = 2'b01,   // asynchronous array read
    BFP_BURST = 2'b10    // clocked burst read
  } bfp_state_e;

  // full state of the top module
  typedef struct packed {
    bfp_state_e           st;       // access state
    logic                 clk_q;    // last sampled flash_clk
    logic                 we_q;     // last sampled we_n
    logic                 started;  // first burst word driven
    logic [`BFP_AW-1:0]   addr;     // latched / burst address
    logic [`BFP_AW-1:0]   fetch;    // prefetch address
    logic [`BFP_DW-1:0]   dout;     // word on the bus
    logic                 dq_oe;    // bus drive enable
    logic                 rdy;      // ready output
    logic                 accel;    // accelerated programming
    logic                 bypass;   // unlock bypass entered
    logic                 refused;  // program refused pulse
  } bfp_top_s;

  // state of the prefetch fifo
  typedef struct packed {
    logic [`BFP_FIFO_PW-1:0] wp;    // write pointer
    logic [`BFP_FIFO_PW-1:0] rp;    // read pointer
    logic [`BFP_FIFO_PW:0]   cnt;   // words held
  } bfp_fifo_s;

endpackage

// ### tb/bfp_flash_if_monitor.sv
// assertions on the pin side of bfp_flash_if
// assumes bfp_pkg compiled first; attached by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module bfp_flash_if_monitor (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire bfp_pkg::bfp_ctl_s ctl,
  input wire logic              addr_data_bus_oe,
  input wire logic              rdy,
  input wire logic              accel_on,
  input wire logic              bypass_on,
  input wire logic              prog_refused
);
  // single domain, reset stops every check
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pin_reset_idle: assert property (!ctl.reset_hw_n |=>
    rdy && !addr_data_bus_oe && !bypass_on) else $error("pin reset left device busy");
  a_accel_follows: assert property (1'b1 |=> accel_on == $past(ctl.vpp_accel))
    else $error("accel flag not one cycle behind pin");
  a_bypass_set: assert property (ctl.vpp_accel && ctl.reset_hw_n |=> bypass_on)
    else $error("bypass not entered");
  a_bypass_sticky: assert property (bypass_on && ctl.reset_hw_n |=> bypass_on)
    else $error("bypass lost");
  a_no_refusal: assert property ((!ctl.vpp_off && ctl.wp_n) [*3] |=> !prog_refused)
    else $error("write refused without cause");
  a_chip_off: assert property (ctl.ce_n |=> !addr_data_bus_oe)
    else $error("bus driven while deselected");
  a_output_off: assert property (ctl.oe_n |=> !addr_data_bus_oe)
    else $error("bus driven with output disabled");
  a_burst_start: assert property (!ctl.ce_n && !ctl.addr_valid_n && ctl.reset_hw_n
    && $rose(ctl.flash_clk) |=> !rdy) else $error("burst start did not drop ready");
  a_ready_cause: assert property ($rose(rdy) |-> $past(ctl.ce_n) || !$past(ctl.reset_hw_n)
    || ($past(ctl.flash_clk) && !$past(ctl.flash_clk, 2))) else $error("ready rose off a clock rise");
endmodule // bfp_flash_if_monitor

bind bfp_flash_if bfp_flash_if_monitor u_mon (.clk(clk), .rst_n(rst_n), .ctl(ctl),
  .addr_data_bus_oe(addr_data_bus_oe), .rdy(rdy), .accel_on(accel_on),
  .bypass_on(bypass_on), .prog_refused(prog_refused));
`default_nettype wire

// ### tb/bfp_host_model.sv
// host controller model: makes the burst clock, takes ready words
// assumes the bench raises burst_en with strobe and address set
`timescale 1ns/1ps
`default_nettype none
module bfp_host_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        burst_en,  // run the interface clock
  input  wire logic        slow,      // long clock period, host stall
  input  wire logic        rdy,       // word valid from device
  input  wire logic [15:0] bus_out,   // word from device
  output logic             fclk,      // interface clock
  output logic             got,       // one word taken
  output logic [15:0]      word       // word taken
);
  logic [2:0] div;        // half period counter
  logic       past_lead;  // the address-latching rise is behind us
  // clock low outside bursts; words taken at rises with ready high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fclk      <= 1'b0;
      div       <= 3'h0;
      got       <= 1'b0;
      word      <= 16'h0000;
      past_lead <= 1'b0;
    end else begin
      got <= 1'b0;
      if (!burst_en) begin
        fclk      <= 1'b0;
        div       <= 3'h0;
        past_lead <= 1'b0;
      end else if (div == (slow ? 3'h5 : 3'h2)) begin
        div  <= 3'h0;
        fclk <= ~fclk;
        // the first rise only latches the address; ready then is idle level
        if (!fclk && rdy && past_lead) begin
          got  <= 1'b1;
          word <= bus_out;
        end
        if (!fclk) begin
          past_lead <= 1'b1;
        end
      end else begin
        div <= div + 3'h1;
      end
    end
  end
endmodule // bfp_host_model
`default_nettype wire

// ### tb/tb_burst_flash_pin_interface.sv
// self-checking bench of bfp_flash_if with host model
// assumes bfp_pkg and design compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_burst_flash_pin_interface;
  logic clk = 1'b0;
  logic rst_n;
  bfp_pkg::bfp_ctl_s ctl_b, ctl;  // bench pins, pins seen by device
  logic [6:0]  addr_hi;
  logic [15:0] bus_in, bus_out, word, exp_w;
  logic oe, rdy, accel_on, bypass_on, prog_refused, fclk, got, burst_en, slow, rd_look;
  logic [15:0] mem [256];  // expected array
  logic [15:0] exp_q [$];  // expected words in order
  int errors = 0;
  int n_checks = 0;
  int i;
  always #5 clk = ~clk;
  // interface clock comes from the host model
  always_comb begin
    ctl = ctl_b;
    ctl.flash_clk = fclk;
  end
  bfp_flash_if dut (.clk(clk), .rst_n(rst_n), .ctl(ctl), .addr_hi(addr_hi),
    .addr_data_bus_in(bus_in), .addr_data_bus_out(bus_out), .addr_data_bus_oe(oe),
    .rdy(rdy), .accel_on(accel_on), .bypass_on(bypass_on), .prog_refused(prog_refused));
  bfp_host_model host (.clk(clk), .rst_n(rst_n), .burst_en(burst_en), .slow(slow),
    .rdy(rdy), .bus_out(bus_out), .fclk(fclk), .got(got), .word(word));
  // result watcher: oldest note against each word seen
  always @(posedge clk) begin
    if (got || rd_look) begin
      exp_w = exp_q.size() ? exp_q.pop_front() : 16'hXXXX;
      `CHK(got ? word : bus_out, exp_w)
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // strobe an address, then pulse write enable with data
  task automatic wr(input logic [22:0] a, input logic [15:0] d, input logic rf);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    ctl_b.ce_n <= 1'b0;
    ctl_b.addr_valid_n <= 1'b0;
    {addr_hi, bus_in} <= a;
    @(posedge clk);
    ctl_b.addr_valid_n <= 1'b1;
    ctl_b.we_n <= 1'b0;
    bus_in <= d;
    @(posedge clk);
    ctl_b.we_n <= 1'b1;
    repeat (4) begin
      @(posedge clk);
      seen |= prog_refused;
    end
    `CHK(seen, rf)
    if (!rf) mem[a[7:0]] = d;
  endtask
  // asynchronous read, bus scrambled once strobe is high
  task automatic rd(input logic [22:0] a);
    @(posedge clk);
    ctl_b.ce_n <= 1'b0;
    ctl_b.addr_valid_n <= 1'b0;
    {addr_hi, bus_in} <= a;
    @(posedge clk);
    ctl_b.addr_valid_n <= 1'b1;
    ctl_b.oe_n <= 1'b0;
    {addr_hi, bus_in} <= 23'($urandom);
    exp_q.push_back(mem[a[7:0]]);
    repeat (3) @(posedge clk);
    `CHK(oe, 1'b1)
    rd_look <= 1'b1;
    @(posedge clk);
    rd_look <= 1'b0;
    ctl_b.oe_n <= 1'b1;
  endtask
  // burst of n words; address scrambled after the start edge
  task automatic brst(input logic [22:0] a, input int n, input logic s);
    int k;
    @(posedge clk);
    slow <= s;
    ctl_b.ce_n <= 1'b0;
    ctl_b.oe_n <= 1'b0;
    ctl_b.addr_valid_n <= 1'b0;
    {addr_hi, bus_in} <= a;
    for (k = 0; k < n; k++) exp_q.push_back(mem[8'(a[7:0] + k)]);
    burst_en <= 1'b1;
    @(posedge fclk);
    @(posedge clk);
    ctl_b.addr_valid_n <= 1'b1;
    {addr_hi, bus_in} <= 23'($urandom);
    for (k = 0; k < 400 && exp_q.size() != 0; k++) @(posedge clk);
    `CHK(exp_q.size(), 0)
    exp_q.delete();
    burst_en <= 1'b0;
    ctl_b.ce_n <= 1'b1;
    ctl_b.oe_n <= 1'b1;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end
  // main sequence
  initial begin
    void'($urandom(97519));
    ctl_b = 9'h1EC;  // all pins inactive, reset and protect pins high, both program pins low
    {addr_hi, bus_in, burst_en, slow, rd_look, rst_n} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 32; i++) wr({15'($urandom), 8'(i)}, 16'($urandom), 1'b0);
    ctl_b.wp_n <= 1'b0;
    wr(23'h021005, 16'hDEAD, 1'b1);
    wr(23'h022006, 16'hBEEF, 1'b1);
    wr(23'h023007, 16'h1234, 1'b0);
    ctl_b.wp_n <= 1'b1;
    ctl_b.vpp_off <= 1'b1;
    wr(23'h000008, 16'h5A5A, 1'b1);
    ctl_b.vpp_off <= 1'b0;
    for (i = 5; i < 9; i++) rd(23'(i));
    brst(23'h000004, 20, 1'b0);
    brst(23'h3F0010, 12, 1'b1);
    @(posedge clk);
    ctl_b.vpp_accel <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({accel_on, bypass_on}, 2'b11)
    ctl_b.vpp_accel <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({accel_on, bypass_on}, 2'b01)
    ctl_b.ce_n <= 1'b0;
    ctl_b.oe_n <= 1'b0;
    ctl_b.addr_valid_n <= 1'b0;
    burst_en <= 1'b1;
    @(posedge fclk);
    repeat (2) @(posedge clk);
    ctl_b.reset_hw_n <= 1'b0;
    burst_en <= 1'b0;
    @(posedge clk);
    ctl_b.reset_hw_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({rdy, oe, bypass_on}, 3'b100)
    complete_run();
  end
endmodule // tb_burst_flash_pin_interface
`default_nettype wire
